/* File: hw/i2cmw_top.sv */
// Two-wire bus master controller with APB register access
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
module i2cmw_top (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Bus pins, open drain
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Transmit interrupt
   output logic tx_irq_o
);
   import i2cmw_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Storage
   i2cmw_state_t state_ff, nxt_state;
   logic [1:0] phase_ff, nxt_phase;
   logic [2:0] bit_ff, nxt_bit;
   logic [7:0] shift_ff, nxt_shift;
   logic scl_lo_ff, nxt_scl_lo, sda_lo_ff, nxt_sda_lo;
   logic first_ff, nxt_first, dir_ff, nxt_dir;
   logic scl_s1_ff, scl_s2_ff, sda_s1_ff, sda_s2_ff, sda_d_ff, scl_d_ff;
   logic [7:0] bus_data_holding_ff;
   logic tx_holding_empty_ff, rx_holding_full_ff, arbitration_lost_ff;
   logic stop_or_restart_seen_ff, nack_irq_flag_ff, ack_ff, ack_state_valid_ff;
   logic en_ff, start_ff, stop_ff, tx_irq_enable_ff, tx_irq_ff;
   logic [15:0] baud_ff;
   logic [1:0] mode_ff;
   logic [31:0] prdata_ff;
   logic pready_ff, pslverr_ff;
   logic ev_start_done, ev_stop_done, ev_first, ev_nack, ev_ack;
   logic ev_rx, ev_arb, xfer_ff;

   i2cmw_tick_if tk();

   i2cmw_tick u_tick (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .tk    (tk.gen)
   );

   assign tk.div = baud_ff;
   assign tk.run = en_ff & (state_ff != S_IDLE);

   ////////////////////////////////////////////////////////////////////////////
   // APB decode
   wire setup = psel_i & ~penable_i;
   wire access = psel_i & penable_i & pready_ff;
   wire wr = access & pwrite_i;
   wire rd = access & ~pwrite_i;
   wire sel_data = (paddr_i == OFF_DATA);
   wire sel_stat = (paddr_i == OFF_STAT);
   wire sel_ctrl = (paddr_i == OFF_CTRL);
   wire sel_baud = (paddr_i == OFF_BAUD);
   wire sel_mode = (paddr_i == OFF_MODE);
   wire sel_state = (paddr_i == OFF_STATE);
   wire mapped = sel_data | sel_stat | sel_ctrl | sel_baud | sel_mode |
                 sel_state;
   wire wr_data = wr & sel_data;
   wire wr_ctrl = wr & sel_ctrl;
   wire rd_data = rd & sel_data;
   wire rd_stat = rd & sel_stat;
   wire slave_only = mode_ff[MD_SLAVE_ONLY];
   wire busy = (state_ff != S_IDLE);
   wire [7:0] stat_word = {tx_holding_empty_ff, rx_holding_full_ff, 1'b0,
                           2'b00, arbitration_lost_ff,
                           stop_or_restart_seen_ff, nack_irq_flag_ff};
   wire [7:0] ctrl_word = {en_ff, start_ff, stop_ff, tx_irq_enable_ff, 4'h0};
   wire [7:0] st_word = {5'h00, busy, ack_ff, ack_state_valid_ff};
   wire [31:0] rd_word =
      sel_data ? {24'h000000, bus_data_holding_ff} :
      sel_stat ? {24'h000000, stat_word} :
      sel_ctrl ? {24'h000000, ctrl_word} :
      sel_baud ? {16'h0000, baud_ff} :
      sel_mode ? {30'h00000000, mode_ff} :
      sel_state ? {24'h000000, st_word} : 32'h00000000;

   ////////////////////////////////////////////////////////////////////////////
   // Bus pin sampling
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         {scl_s1_ff, scl_s2_ff, scl_d_ff} <= 3'h7;
         {sda_s1_ff, sda_s2_ff, sda_d_ff} <= 3'h7;
      end else begin
         {scl_s1_ff, scl_s2_ff, scl_d_ff} <= {scl_i, scl_s1_ff, scl_s2_ff};
         {sda_s1_ff, sda_s2_ff, sda_d_ff} <= {sda_i, sda_s1_ff, sda_s2_ff};
      end
   end

   // Stop and start conditions seen on the bus
   wire bus_stop = scl_s2_ff & scl_d_ff & sda_s2_ff & ~sda_d_ff;
   wire bus_start = scl_s2_ff & scl_d_ff & ~sda_s2_ff & sda_d_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Bit engine
   wire tick = tk.tick;
   // Clock stretching: hold the high phase until the line is seen high
   wire stall = (phase_ff == PH_HIGH) & ~scl_s2_ff;
   wire step = tick & ~stall;
   // address byte read bit picks receive for data bytes
   wire tx_now = first_ff | ~dir_ff;
   wire go_start = start_ff & ~tx_holding_empty_ff & ~slave_only;
   wire last_bit = (bit_ff == BIT_LAST);

   always_comb begin
      nxt_state = state_ff;
      nxt_phase = phase_ff;
      nxt_bit = bit_ff;
      nxt_shift = shift_ff;
      nxt_scl_lo = scl_lo_ff;
      nxt_sda_lo = sda_lo_ff;
      nxt_first = first_ff;
      nxt_dir = dir_ff;
      ev_start_done = 1'b0;
      ev_stop_done = 1'b0;
      ev_first = 1'b0;
      ev_nack = 1'b0;
      ev_ack = 1'b0;
      ev_rx = 1'b0;
      ev_arb = 1'b0;
      if (step) begin
         nxt_phase = phase_ff + 2'h1;
      end
      if (!en_ff) begin
         nxt_state = S_IDLE;
         nxt_phase = PH_DATA;
         nxt_scl_lo = 1'b0;
         nxt_sda_lo = 1'b0;
      end else begin
         case (state_ff)
            S_IDLE: begin
               nxt_phase = PH_DATA;
               if (go_start) begin
                  nxt_state = S_START;
               end else if (stop_ff) begin
                  ev_stop_done = 1'b1;
               end
            end
            S_START: begin
               if (step) begin
                  case (phase_ff)
                     PH_DATA: nxt_sda_lo = 1'b0;
                     PH_RISE: nxt_scl_lo = 1'b0;
                     PH_HIGH: nxt_sda_lo = 1'b1;
                     default: begin
                        nxt_scl_lo = 1'b1;
                        ev_start_done = 1'b1;
                        nxt_shift = bus_data_holding_ff;
                        nxt_dir = bus_data_holding_ff[0];
                        nxt_first = 1'b1;
                        nxt_bit = BIT_FIRST;
                        nxt_state = S_BIT;
                     end
                  endcase
               end
            end
            S_BIT: begin
               if (step) begin
                  case (phase_ff)
                     // shift out most significant bit first
                     PH_DATA: nxt_sda_lo = tx_now & ~shift_ff[7];
                     PH_RISE: nxt_scl_lo = 1'b0;
                     PH_HIGH: nxt_scl_lo = 1'b0;
                     default: begin
                        nxt_scl_lo = 1'b1;
                        nxt_shift = {shift_ff[6:0], sda_s2_ff};
                        nxt_bit = bit_ff - 3'h1;
                        ev_first = (bit_ff == BIT_FIRST) & tx_now;
                        if (tx_now & shift_ff[7] & ~sda_s2_ff) begin
                           ev_arb = 1'b1;
                           nxt_scl_lo = 1'b0;
                           nxt_sda_lo = 1'b0;
                           nxt_state = S_IDLE;
                        end else if (last_bit) begin
                           nxt_state = S_ACK;
                        end
                     end
                  endcase
               end
            end
            S_ACK: begin
               if (step) begin
                  case (phase_ff)
                     PH_DATA: nxt_sda_lo = ~tx_now & ~stop_ff;
                     PH_RISE: nxt_scl_lo = 1'b0;
                     PH_HIGH: nxt_scl_lo = 1'b0;
                     default: begin
                        nxt_scl_lo = 1'b1;
                        nxt_sda_lo = 1'b0;
                        nxt_first = 1'b0;
                        nxt_bit = BIT_FIRST;
                        if (tx_now & sda_s2_ff) begin
                           ev_nack = 1'b1;
                           nxt_state = S_HALT;
                        end else begin
                           ev_ack = tx_now;
                           ev_rx = ~tx_now;
                           if (stop_ff) begin
                              nxt_state = S_STOP;
                           end else if (start_ff) begin
                              nxt_state = S_START;
                           end else if (dir_ff) begin
                              nxt_state = S_BIT;
                           end else if (tx_holding_empty_ff) begin
                              nxt_state = S_WAIT;
                           end else begin
                              nxt_shift = bus_data_holding_ff;
                              nxt_state = S_BIT;
                           end
                        end
                     end
                  endcase
               end
            end
            S_WAIT, S_HALT: begin
               nxt_phase = PH_DATA;
               // halt ends by stop or start only
               if (tick) begin
                  if (stop_ff) begin
                     nxt_state = S_STOP;
                  end else if (start_ff) begin
                     nxt_state = S_START;
                  end else if (state_ff == S_WAIT && !tx_holding_empty_ff) begin
                     nxt_shift = bus_data_holding_ff;
                     nxt_state = S_BIT;
                  end
               end
            end
            S_STOP: begin
               if (step) begin
                  case (phase_ff)
                     PH_DATA: nxt_sda_lo = 1'b1;
                     PH_RISE: nxt_scl_lo = 1'b0;
                     PH_HIGH: nxt_scl_lo = 1'b0;
                     default: begin
                        nxt_sda_lo = 1'b0;
                        ev_stop_done = 1'b1;
                        nxt_state = S_IDLE;
                     end
                  endcase
               end
            end
            default: begin
               nxt_state = S_IDLE;
               nxt_scl_lo = 1'b0;
               nxt_sda_lo = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff <= S_IDLE;
         phase_ff <= PH_DATA;
         bit_ff <= BIT_FIRST;
         shift_ff <= 8'h00;
         {scl_lo_ff, sda_lo_ff, first_ff, dir_ff} <= 4'h0;
      end else begin
         state_ff <= nxt_state;
         phase_ff <= nxt_phase;
         bit_ff <= nxt_bit;
         shift_ff <= nxt_shift;
         {scl_lo_ff, sda_lo_ff} <= {nxt_scl_lo, nxt_sda_lo};
         {first_ff, dir_ff} <= {nxt_first, nxt_dir};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers and flags
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         {en_ff, start_ff, stop_ff, tx_irq_enable_ff} <= 4'h0;
         baud_ff <= BAUD_RST;
         mode_ff <= MODE_RST;
         bus_data_holding_ff <= 8'h00;
      end else begin
         if (wr_ctrl) begin
            en_ff <= pwdata_i[CTL_EN];
            tx_irq_enable_ff <= pwdata_i[CTL_TXIE];
         end
         // start bit ignored in slave-only mode
         if (slave_only) begin
            start_ff <= 1'b0;
         end else if (wr_ctrl) begin
            start_ff <= pwdata_i[CTL_START];
         end else if (ev_start_done) begin
            start_ff <= 1'b0;
         end
         // stop waits for the current byte
         if (wr_ctrl) begin
            stop_ff <= pwdata_i[CTL_STOP];
         end else if (ev_stop_done) begin
            stop_ff <= 1'b0;
         end
         if (wr & sel_baud) begin
            baud_ff <= pwdata_i[15:0];
         end
         if (wr & sel_mode) begin
            mode_ff <= pwdata_i[1:0];
         end
         if (wr_data) begin
            bus_data_holding_ff <= pwdata_i[7:0];
         end else if (ev_rx) begin
            bus_data_holding_ff <= shift_ff;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_holding_empty_ff <= TX_EMPTY_RST;
         {rx_holding_full_ff, arbitration_lost_ff} <= 2'h0;
         {stop_or_restart_seen_ff, nack_irq_flag_ff} <= 2'h0;
         {ack_ff, ack_state_valid_ff, xfer_ff} <= 3'h0;
      end else begin
         // Own first start is not a restart: arm after a byte
         if (ev_ack | ev_nack | ev_rx) begin
            xfer_ff <= 1'b1;
         end else if (!busy) begin
            xfer_ff <= 1'b0;
         end
         if (wr_data) begin
            tx_holding_empty_ff <= 1'b0;
         end else if (ev_first | ev_nack) begin
            tx_holding_empty_ff <= 1'b1;
         end
         // received byte sets full, data read clears
         if (ev_rx) begin
            rx_holding_full_ff <= 1'b1;
         end else if (rd_data) begin
            rx_holding_full_ff <= 1'b0;
         end
         if (ev_arb) begin
            arbitration_lost_ff <= 1'b1;
         end else if (rd_stat) begin
            arbitration_lost_ff <= 1'b0;
         end
         if (bus_stop | (bus_start & xfer_ff)) begin
            stop_or_restart_seen_ff <= 1'b1;
         end else if (rd_stat) begin
            stop_or_restart_seen_ff <= 1'b0;
         end
         if (ev_nack) begin
            nack_irq_flag_ff <= 1'b1;
         end else if (rd_stat) begin
            nack_irq_flag_ff <= 1'b0;
         end
         if (ev_ack | ev_nack) begin
            ack_ff <= ev_ack;
            ack_state_valid_ff <= 1'b1;
         end else if (ev_start_done) begin
            ack_state_valid_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         prdata_ff <= 32'h00000000;
         {pready_ff, pslverr_ff, tx_irq_ff} <= 3'h0;
      end else begin
         prdata_ff <= setup ? rd_word : prdata_ff;
         pready_ff <= setup;
         pslverr_ff <= setup & ~mapped;
         tx_irq_ff <= tx_irq_enable_ff & tx_holding_empty_ff & en_ff;
      end
   end

   assign prdata_o = prdata_ff;
   assign pready_o = pready_ff;
   assign pslverr_o = pslverr_ff;
   assign tx_irq_o = tx_irq_ff;
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe_o = scl_lo_ff;
   assign sda_oe_o = sda_lo_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   start_cond_a: assert property (
      (state_ff == S_START && phase_ff == PH_HIGH && step && en_ff)
      |=> sda_oe_o && !scl_oe_o)
      else $error("start not made with clock released");
   stop_cond_a: assert property (
      (state_ff == S_STOP && phase_ff == PH_FALL && step && en_ff)
      |=> !sda_oe_o && !scl_oe_o ##1 state_ff == S_IDLE)
      else $error("stop not made with clock released");
   sw_start_a: assert property (
      (state_ff == S_START && $past(state_ff) == S_IDLE) |-> $past(start_ff))
      else $error("start without software request");
   byte_end_a: assert property (
      ((state_ff == S_START || state_ff == S_STOP) && $changed(state_ff))
      |-> $past(state_ff) != S_BIT)
      else $error("condition cut into a byte");
   slave_block_a: assert property (
      ($past(slave_only) && slave_only) |-> !start_ff && state_ff != S_START)
      else $error("start accepted in slave-only mode");
   irq_gate_a: assert property (
      tx_irq_o |-> $past(tx_irq_enable_ff) && $past(tx_holding_empty_ff))
      else $error("transmit interrupt without enable");
   empty_flag_a: assert property (
      (ev_first && !wr_data) |=> tx_holding_empty_ff [*2])
      else $error("empty flag not set after first bit");
   nack_halt_a: assert property (
      ev_nack |=> nack_irq_flag_ff && ack_state_valid_ff && !ack_ff &&
                  state_ff == S_HALT && tx_holding_empty_ff)
      else $error("nack not handled");
   rx_full_a: assert property (
      ev_rx |=> rx_holding_full_ff && bus_data_holding_ff == $past(shift_ff))
      else $error("received byte not posted");
endmodule // i2cmw_top

/* File: common/i2cmw_pkg.sv */
// Constants, field layout and state codes of the two-wire master controller
//
// Behaviour
// - As master, make a start by pulling data low while clock is high.
// - As master, make a stop by releasing data low-to-high while clock high.
// - Start and stop happen only after software writes the start or stop bit.
// - A byte under way, with its acknowledge, finishes before start or stop.
// - Two-bit mode: master/slave or slave-only, with 7- or 10-bit own address; the 10-bit bit (bit 0) is only stored and read back here.
// - In slave-only mode the start bit is ignored.
// - Transmit interrupt is raised only while its enable bit is set.
// - Transmit-holding-empty flag shows its condition regardless of the enable.
// - Status exposes six flags: empty, full, matched, lost, stop, nack; matched (bit 5) always reads 0 here.
// - During a write, address remainder and data bytes shift out on data.
// - Slave acknowledges low in the next clock-high; acknowledge bit then set.
// - Transmit interrupt asserts once the first bit of a byte is sent.
// - Software feeds each byte then sets stop; last byte ends, then stop.
// - On nack: set nack flag and ack-valid, clear ack, halt the transfer.
// - After nack halt, stop or start ends it; pending data is discarded.
// - Empty flag resets to 1, set while holding is empty, cleared on write.
// - Full flag sets when a byte is received while enabled; read clears it.
package i2cmw_pkg;
   // Register byte addresses
   localparam logic [7:0] OFF_DATA = 8'h00;
   localparam logic [7:0] OFF_STAT = 8'h04;
   localparam logic [7:0] OFF_CTRL = 8'h08;
   localparam logic [7:0] OFF_BAUD = 8'h0C;
   localparam logic [7:0] OFF_MODE = 8'h10;
   localparam logic [7:0] OFF_STATE = 8'h14;
   // Control bits
   localparam int CTL_EN = 7;
   localparam int CTL_START = 6;
   localparam int CTL_STOP = 5;
   localparam int CTL_TXIE = 4;
   // Mode bits
   localparam int MD_SLAVE_ONLY = 1;
   localparam int MD_TEN_BIT = 0;
   // Reset values
   localparam logic [15:0] BAUD_RST = 16'h003D;
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic TX_EMPTY_RST = 1'b1;
   // Bit sequencing
   localparam logic [2:0] BIT_FIRST = 3'h7;
   localparam logic [2:0] BIT_LAST = 3'h0;
   localparam logic [1:0] PH_DATA = 2'h0;
   localparam logic [1:0] PH_RISE = 2'h1;
   localparam logic [1:0] PH_HIGH = 2'h2;
   localparam logic [1:0] PH_FALL = 2'h3;

   typedef enum logic [6:0] {
      S_IDLE  = 7'h01,
      S_START = 7'h02,
      S_BIT   = 7'h04,
      S_ACK   = 7'h08,
      S_WAIT  = 7'h10,
      S_STOP  = 7'h20,
      S_HALT  = 7'h40
   } i2cmw_state_t;
endpackage

/* File: common/i2cmw_tick_if.sv */
// Quarter-bit tick request and answer between controller and divider
`timescale 1ns/100ps
interface i2cmw_tick_if;
   logic [15:0] div;
   logic run;
   logic tick;
   modport ctl (output div, output run, input tick);
   modport gen (input div, input run, output tick);
endinterface

/* File: hw/i2cmw_tick.sv */
// Programmable divider making one-cycle quarter-bit ticks
`timescale 1ns/100ps
module i2cmw_tick (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Tick carrier
   i2cmw_tick_if.gen tk
);
   logic [15:0] cnt_ff;
   logic tick_ff;
   wire cnt_end = (cnt_ff == tk.div);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_ff <= 16'h0000;
         tick_ff <= 1'b0;
      end else if (!tk.run) begin
         cnt_ff <= 16'h0000;
         tick_ff <= 1'b0;
      end else begin
         cnt_ff <= cnt_end ? 16'h0000 : cnt_ff + 16'h0001;
         tick_ff <= cnt_end;
      end
   end

   assign tk.tick = tick_ff;
endmodule // i2cmw_tick

/* File: verif/i2cmw_slave_model.sv */
// Bus slave that records written bytes and acknowledges or refuses them
`timescale 1ns/100ps
module i2cmw_slave_model #(
   // Byte sent back on a read
   parameter logic [7:0] TX_BYTE = 8'hC3
) (
   // Bus lines
   input wire logic scl_i,
   input wire logic sda_i,
   // Control and observation
   input wire logic nack_i,
   output logic sda_oe_o,
   output logic [15:0] rx_hist_o,
   output logic [7:0] starts_o,
   output logic [7:0] stops_o
);
   int cnt;
   logic [7:0] sh;
   logic rd, addr;
   initial begin
      rd = 0;
      addr = 0;
      sda_oe_o = 0;
      rx_hist_o = 0;
      starts_o = 0;
      stops_o = 0;
      cnt = 0;
      sh = 0;
   end
   // Start seen: data falls while clock high
   always @(negedge sda_i) begin
      if (scl_i === 1'b1 && $time > 0) begin
         starts_o = starts_o + 1;
         cnt = 0;
         addr = 1;
         rd = 0;
      end
   end
   always @(posedge sda_i) begin
      if (scl_i === 1'b1 && $time > 0) begin
         stops_o = stops_o + 1;
      end
   end
   always @(posedge scl_i) begin
      if (cnt < 8) begin
         sh = {sh[6:0], sda_i};
         cnt = cnt + 1;
         if (cnt == 8) begin
            rx_hist_o = {rx_hist_o[7:0], sh};
            if (addr) rd = sh[0];
         end
      end else begin
         // A master refusal ends the read
         if (rd && !addr && sda_i) rd = 0;
         addr = 0;
         cnt = 0;
      end
   end
   // acknowledge held low; read data driven after the address
   always @(negedge scl_i) begin
      if (cnt == 8) sda_oe_o = (addr || !rd) && !nack_i;
      else sda_oe_o = rd && !addr && !TX_BYTE[7 - cnt];
   end
endmodule // i2cmw_slave_model

/* File: verif/i2c_master_write_control_tb_top.sv */
// Register-level testbench of the two-wire master controller
`timescale 1ns/100ps
module i2c_master_write_control_tb_top;
   import i2cmw_pkg::*;
   logic clk_i, rst_i, psel, pen, pwr, nack, err;
   logic [7:0] paddr, starts, stops;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, s_oe, irq;
   logic [15:0] hist;
   wire logic scl, sda;
   int mismatches, samples_checked;
   // Pull-ups: a line is low while any party enables its driver
   assign scl = !scl_oe;
   assign sda = !(sda_oe || s_oe);
   i2cmw_top dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_o(sda_oe), .tx_irq_o(irq));
   i2cmw_slave_model slave (.scl_i(scl), .sda_i(sda), .nack_i(nack),
      .sda_oe_o(s_oe), .rx_hist_o(hist), .starts_o(starts), .stops_o(stops));
   always #20 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_i);
      psel <= 1;
      pen <= 0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      pen <= 1;
      @(posedge clk_i);
      while (pready !== 1'b1) @(posedge clk_i);
      r = prdata;
      err = pslverr;
      psel <= 0;
      pen <= 0;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
         mismatches++;
      end
   endtask
   task automatic poll(input logic [7:0] a, input int b, input logic v);
      logic [31:0] r;
      r = {32{~v}};
      for (int n = 0; n < 500 && r[b] !== v; n++) apb(0, a, 0, r);
      chk({31'h0, r[b]}, {63'h0, v});
   endtask
   task end_sim;
      if (mismatches == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #2000000;
      mismatches++;
      end_sim;
   end
   initial begin
      clk_i = 0; rst_i = 1; psel = 0; pen = 0; pwr = 0; paddr = 0;
      pwdata = 0; nack = 0; err = 0; mismatches = 0; samples_checked = 0;
      repeat (5) @(posedge clk_i);
      rst_i <= 0;
      apb(0, OFF_STAT, 0, rd); chk(rd, 32'h80);
      apb(0, OFF_BAUD, 0, rd); chk(rd, {16'h0, BAUD_RST});
      apb(0, 8'h18, 0, rd);
      chk({rd, 31'h0, err}, {32'h0, 31'h0, 1'b1});
      apb(1, OFF_BAUD, 32'h1, rd);
      apb(1, OFF_CTRL, 32'h80, rd);
      repeat (3) @(posedge clk_i);
      chk({31'h0, irq}, 0);
      apb(0, OFF_STAT, 0, rd); chk(rd & 32'h80, 32'h80);
      apb(1, OFF_CTRL, 32'h90, rd);
      repeat (3) @(posedge clk_i);
      chk({31'h0, irq}, 1);
      // Start request while in slave-only mode
      apb(1, OFF_MODE, 32'h2, rd);
      apb(1, OFF_DATA, 32'h11, rd);
      apb(1, OFF_CTRL, 32'hC0, rd);
      repeat (100) @(posedge clk_i);
      chk({24'h0, starts}, 0);
      apb(0, OFF_CTRL, 0, rd); chk(rd & 32'h40, 0);
      apb(0, OFF_MODE, 0, rd); chk(rd, 32'h2);
      apb(1, OFF_MODE, 0, rd);
      // Address, one data byte, stop requested mid-byte
      apb(1, OFF_DATA, 32'hA0, rd);
      apb(1, OFF_CTRL, 32'hC0, rd);
      poll(OFF_STAT, 7, 1);
      apb(1, OFF_DATA, 32'h5A, rd);
      poll(OFF_STAT, 7, 1);
      apb(1, OFF_CTRL, 32'hA0, rd);
      poll(OFF_STATE, 2, 0);
      chk({16'h0, hist}, 32'hA05A);
      chk({16'h0, starts, stops}, 32'h0101);
      apb(0, OFF_STATE, 0, rd); chk(rd, 32'h3);
      apb(0, OFF_STAT, 0, rd); chk(rd, 32'h82);
      // Refused address byte halts the transfer
      nack <= 1;
      apb(1, OFF_DATA, 32'h42, rd);
      apb(1, OFF_CTRL, 32'hC0, rd);
      poll(OFF_STATE, 1, 0);
      apb(0, OFF_STATE, 0, rd); chk(rd & 32'h3, 32'h1);
      apb(0, OFF_STAT, 0, rd); chk(rd, 32'h81);
      apb(1, OFF_CTRL, 32'hA0, rd);
      poll(OFF_STATE, 2, 0);
      chk({16'h0, starts, stops}, 32'h0202);
      chk({31'h0, sda_o | scl_o}, 0);
      // Read: address with read bit, stop set during the second byte
      nack <= 0;
      apb(1, OFF_DATA, 32'hA1, rd);
      apb(1, OFF_CTRL, 32'hC0, rd);
      poll(OFF_STAT, 6, 1);
      apb(1, OFF_CTRL, 32'hA0, rd);
      poll(OFF_STATE, 2, 0);
      apb(0, OFF_STAT, 0, rd); chk(rd, 32'hC2);
      apb(0, OFF_DATA, 0, rd); chk(rd, 32'hC3);
      apb(0, OFF_STAT, 0, rd); chk(rd & 32'h40, 0);
      chk({16'h0, starts, stops}, 32'h0303);
      end_sim;
   end
endmodule // i2c_master_write_control_tb_top
